// File: hw/sbl_params.svh
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

// Register byte offsets
`define SBL_OFF_RX 5'h00
`define SBL_OFF_TX 5'h04
`define SBL_OFF_STAT 5'h08
`define SBL_OFF_SEL 5'h0c
`define SBL_OFF_CTRL 5'h10

// Control field positions
`define SBL_CTRL_CLOCK_SELECT_HI 4
`define SBL_CTRL_CLOCK_SELECT_LO 3
`define SBL_CTRL_POL 2
`define SBL_CTRL_PHA 1
`define SBL_CTRL_LSB 0

// Status field positions
`define SBL_ST_ERR 7
`define SBL_ST_RRDY 6
`define SBL_ST_TRDY 5
`define SBL_ST_BUSY 4
`define SBL_ST_TOE 3
`define SBL_ST_ROE 2

// Reset values
`define SBL_RST_CTRL 5'h00
`define SBL_RST_SEL 8'h00
`define SBL_RST_DATA 8'h00

// Bits per byte transfer
`define SBL_BITS 8

`endif

// File: hw/sbl_pkg.sv
`default_nettype none
package sbl_pkg;
   typedef struct packed {
      logic [4:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sbl_req_s;
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic [7:0] sel;
   } sbl_link_s;
   typedef enum logic [1:0] {SBL_IDLE, SBL_LEAD, SBL_TRAIL} sbl_state_e;
endpackage
`default_nettype wire

// File: hw/sbl_fifo.sv
`default_nettype none
module sbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem_reg[rp_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/sbl_master.sv
`include "sbl_params.svh"
`default_nettype none
module sbl_master #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire sbl_pkg::sbl_req_s req,
   output logic [7:0] rdata,
   // Serial link
   output sbl_pkg::sbl_link_s link,
   input wire logic miso
);
   logic [4:0] ctrl_reg;
   logic [7:0] sel_reg;
   logic [7:0] rx_reg;
   logic rrdy_reg;
   logic toe_reg;
   logic roe_reg;
   logic [7:0] rdata_reg;
   sbl_pkg::sbl_link_s link_reg;
   sbl_pkg::sbl_state_e state_reg;
   logic [2:0] div_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic [7:0] in_reg;
   logic [2:0] miso_sync_reg;
   logic miso_reg;

   logic wr_tx;
   logic wr_st;
   logic rd_rx;
   logic trdy;
   logic busy;
   logic done;
   logic half_tick;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic rx_take;

   assign rdata = rdata_reg;
   assign link = link_reg;

   assign wr_tx = req.wr && req.addr == `SBL_OFF_TX;
   assign wr_st = req.wr && req.addr == `SBL_OFF_STAT;
   assign rd_rx = req.rd && req.addr == `SBL_OFF_RX;
   assign busy = state_reg != sbl_pkg::SBL_IDLE;
   // Single-byte staging keeps transmit ready as a clean one-byte handshake
   assign trdy = !busy && !fifo_out_valid && fifo_in_ready;

   function automatic logic [7:0] bit_rev(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   // Control and slave select
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= `SBL_RST_CTRL;
         sel_reg <= `SBL_RST_SEL;
      end else if (req.wr && !busy && req.addr == `SBL_OFF_CTRL) begin
         ctrl_reg <= req.wdata[4:0];
      end else if (req.wr && req.addr == `SBL_OFF_SEL) begin
         sel_reg <= req.wdata;
      end
   end

   // Transmit staging FIFO; only written when ready so overrun bytes are dropped
   sbl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(wr_tx && trdy),
      .in_ready(fifo_in_ready),
      .in_data(req.wdata),
      .out_valid(fifo_out_valid),
      .out_ready(!busy),
      .out_data(fifo_out_data)
   );

   // MISO from the pin: three stages, change taken when stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         miso_sync_reg <= 3'h0;
         miso_reg <= 1'b0;
      end else begin
         miso_sync_reg <= {miso_sync_reg[1:0], miso};
         if (miso_sync_reg[1] == miso_sync_reg[2]) begin
            miso_reg <= miso_sync_reg[2];
         end
      end
   end

   // Half-period divider: (clock select + 1) bus clocks per half period
   assign half_tick = div_reg == ctrl_reg[`SBL_CTRL_CLOCK_SELECT_HI:`SBL_CTRL_CLOCK_SELECT_LO];
   assign done = state_reg == sbl_pkg::SBL_TRAIL && half_tick && bit_reg == 4'(`SBL_BITS - 1);

   always_ff @(posedge clk) begin
      if (srst || !busy || half_tick) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   // Shift engine; leading edge samples, trailing edge shifts out next bit
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= sbl_pkg::SBL_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= `SBL_RST_DATA;
         in_reg <= `SBL_RST_DATA;
      end else begin
         unique case (state_reg)
            sbl_pkg::SBL_IDLE: begin
               bit_reg <= 4'h0;
               if (fifo_out_valid) begin
                  sh_reg <= ctrl_reg[`SBL_CTRL_LSB] ? fifo_out_data : bit_rev(fifo_out_data);
                  state_reg <= sbl_pkg::SBL_LEAD;
               end
            end
            sbl_pkg::SBL_LEAD: begin
               if (half_tick) begin
                  in_reg <= {miso_reg, in_reg[7:1]};
                  state_reg <= sbl_pkg::SBL_TRAIL;
               end
            end
            sbl_pkg::SBL_TRAIL: begin
               if (half_tick) begin
                  sh_reg <= {1'b0, sh_reg[7:1]};
                  bit_reg <= bit_reg + 1'b1;
                  state_reg <= done ? sbl_pkg::SBL_IDLE : sbl_pkg::SBL_LEAD;
               end
            end
         endcase
      end
   end

   // Link outputs registered; first half level equals phase, so phase alone picks the sample edge
   always_ff @(posedge clk) begin
      if (srst) begin
         link_reg <= '0;
      end else begin
         link_reg.sclk <= ctrl_reg[`SBL_CTRL_PHA] ^ (state_reg == sbl_pkg::SBL_TRAIL);
         if (!busy) begin
            link_reg.sclk <= ctrl_reg[`SBL_CTRL_POL];
         end
         link_reg.mosi <= busy ? sh_reg[0] : 1'b0;
         link_reg.sel <= sel_reg;
      end
   end

   // Receive byte, ready and overrun flags; set wins over clear
   assign rx_take = done;
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_reg <= `SBL_RST_DATA;
         rrdy_reg <= 1'b0;
         roe_reg <= 1'b0;
         toe_reg <= 1'b0;
      end else begin
         if (rx_take) begin
            // All eight samples are already in; first sampled bit sits at bit 0
            rx_reg <= ctrl_reg[`SBL_CTRL_LSB] ? in_reg : bit_rev(in_reg);
         end
         if (rx_take) begin
            rrdy_reg <= 1'b1;
         end else if (rd_rx) begin
            rrdy_reg <= 1'b0;
         end
         if (rx_take && rrdy_reg && !rd_rx) begin
            roe_reg <= 1'b1;
         end else if (wr_st && (req.wdata[`SBL_ST_ROE] || req.wdata[`SBL_ST_ERR])) begin
            roe_reg <= 1'b0;
         end
         if (wr_tx && !trdy) begin
            toe_reg <= 1'b1;
         end else if (wr_st && (req.wdata[`SBL_ST_TOE] || req.wdata[`SBL_ST_ERR])) begin
            toe_reg <= 1'b0;
         end
      end
   end

   // Register read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            `SBL_OFF_RX: rdata_reg <= rx_reg;
            `SBL_OFF_STAT: begin
               rdata_reg <= {toe_reg | roe_reg, rrdy_reg, trdy, busy, toe_reg, roe_reg, 2'b00};
            end
            `SBL_OFF_SEL: rdata_reg <= sel_reg;
            `SBL_OFF_CTRL: rdata_reg <= {3'h0, ctrl_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: dv/sbl_master_props.sv
`default_nettype none
module sbl_master_props (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire sbl_pkg::sbl_req_s req,
   input wire logic [7:0] rdata,
   // Serial link
   input wire sbl_pkg::sbl_link_s link,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [4:0] ctrl_reg;
   logic [5:0] gap_reg;
   logic [4:0] edge_reg;
   logic sclk_reg;
   logic flip;
   assign flip = link.sclk != sclk_reg;
   // Shadow is exact only because control is never written mid-transfer
   always_ff @(posedge clk) begin
      sclk_reg <= link.sclk;
      if (srst) ctrl_reg <= 5'h00;
      else if (req.wr && req.addr == 5'h10) ctrl_reg <= req.wdata[4:0];
   end
   always_ff @(posedge clk) begin
      if (srst) gap_reg <= 6'h00;
      else if (flip) gap_reg <= 6'h01;
      else if (gap_reg < 6'h28) gap_reg <= gap_reg + 6'h01;
   end
   // Gap over a half period starts a frame, so idle level changes from control writes drop out
   always_ff @(posedge clk) begin
      if (srst || gap_reg == 6'h14) edge_reg <= 5'h00;
      else if (flip && gap_reg > {4'h0, ctrl_reg[4:3]} + 6'h01) edge_reg <= 5'h01;
      else if (flip) edge_reg <= edge_reg + 5'h01;
   end
   sequence s_tx_wr;
      req.wr && req.addr == 5'h04;
   endsequence
   sequence s_stat_rd;
      req.rd && req.addr == 5'h08;
   endsequence
   sequence s_rx_rd;
      req.rd && req.addr == 5'h00;
   endsequence
   a_tx_overrun_set: assert property (s_tx_wr ##2 s_tx_wr ##2 s_stat_rd |=> rdata[3] && rdata[7])
      else $error("transmit overrun not flagged");
   a_rx_read_clears: assert property (s_rx_rd ##2 s_stat_rd |=> !rdata[6])
      else $error("receive ready still set after read");
   a_status_shape: assert property (s_stat_rd |=> rdata[1:0] == 2'b00 && rdata[7] == (rdata[3] | rdata[2]))
      else $error("status reserved bits or error summary wrong");
   a_ctrl_read_back: assert property (req.rd && req.addr == 5'h10 |=> rdata == {3'b000, ctrl_reg})
      else $error("control read back wrong");
   a_unmapped_zero: assert property (req.rd && !(req.addr inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10})
      |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_select_pins: assert property (req.wr && req.addr == 5'h0c |-> ##2 link.sel == $past(req.wdata, 2))
      else $error("select lines do not follow register");
   a_sclk_half_period: assert property (flip && gap_reg != 6'h00 && gap_reg <= 6'h04
      |-> gap_reg == {4'h0, ctrl_reg[4:3]} + 6'h01)
      else $error("serial clock half period wrong");
   a_frame_edges: assert property (gap_reg == 6'h14 |-> edge_reg == 5'h10 || edge_reg == 5'h00)
      else $error("frame does not carry sixteen clock edges");
endmodule
bind sbl_master sbl_master_props u_props (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
   .link(link), .miso(miso));
`default_nettype wire

// File: dv/sbl_slave.sv
`default_nettype none
module sbl_slave (
   // Clock
   input wire logic clk,
   // Serial link
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Bench side
   input wire logic pha,
   input wire logic lsb,
   input wire logic load,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_d;
   logic samp;
   logic [7:0] sh;
   logic [3:0] n;
   assign samp = pha ? (sclk_d && !sclk) : (!sclk_d && sclk);
   always_ff @(posedge clk) begin
      sclk_d <= sclk;
      if (load) begin
         sh <= tx_byte;
         n <= 4'h0;
      end else if (samp) begin
         rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         n <= n + 4'h1;
      end
   end
   // Next bit right after a sample edge; after the frame the inverse of the last bit
   assign miso = (n < 4'h8) ? sh[lsb ? n[2:0] : 3'h7 - n[2:0]] : !sh[lsb ? 3'h7 : 3'h0];
endmodule
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic srst;
   logic miso;
   logic ld;
   logic [7:0] sb;
   logic [7:0] d;
   logic [7:0] e;
   logic [7:0] tx;
   logic [7:0] srx;
   logic [4:0] ctl;
   sbl_pkg::sbl_req_s req;
   sbl_pkg::sbl_link_s link;
   int fail_count;
   int comparisons;
   logic [7:0] exp_q[$];
   logic [7:0] d_unused_guard;
   sbl_master DUT (.clk(clk), .srst(srst), .req(req), .rdata(d_unused_guard), .link(link),
      .miso(miso));
   sbl_slave PEER (.clk(clk), .sclk(link.sclk), .mosi(link.mosi), .miso(miso), .pha(ctl[1]),
      .lsb(ctl[0]), .load(ld), .tx_byte(sb), .rx_byte(srx));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string n, logic [7:0] x, logic [7:0] s);
      comparisons++;
      if (s !== x) begin
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
         fail_count++;
      end
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] v);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = d_unused_guard;
   endtask
   task automatic results;
      $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_bit(int b);
      bit ok;
      ok = 1'b0;
      for (int k = 0; k < 100 && !ok; k++) begin
         rd(5'h08);
         ok = d[b] === 1'b1;
      end
      if (!ok) begin
         $display("CHECK FAILED status bit %0d expected 1 seen 0", b);
         fail_count++;
         results();
      end
   endtask
   task automatic xfer;
      @(posedge clk);
      sb <= 8'($urandom);
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      exp_q.push_back(sb);
      tx = 8'($urandom);
      wr(5'h04, tx);
   endtask
   initial begin
      req = '0;
      srst = 1'b1;
      ld = 1'b1;
      sb = 8'h00;
      ctl = 5'h00;
      fail_count = 0;
      comparisons = 0;
      void'($urandom(42400));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a <= 20; a += 4) begin
         rd(5'(a));
         chk("reset value", (a == 8) ? 8'h20 : 8'h00, d);
      end
      wr(5'h00, 8'h5a);
      rd(5'h00);
      chk("receive_byte", 8'h00, d);
      tx = 8'($urandom);
      wr(5'h0c, tx);
      rd(5'h0c);
      chk("slave_select", tx, d);
      chk("select pins", tx, link.sel);
      for (int i = 0; i < 32; i++) begin
         ctl = 5'(i);
         wr(5'h10, {3'b000, ctl});
         rd(5'h10);
         chk("link_control", {3'b000, ctl}, d);
         chk("idle clock", {7'h00, ctl[2]}, {7'h00, link.sclk});
         xfer();
         wait_bit(6);
         rd(5'h00);
         e = exp_q.pop_front();
         // Input synchroniser lag only lets the slowest divide carry read data back
         if (ctl[4:3] == 2'b11) chk("receive_byte", e, d);
         chk("peer byte", tx, srx);
         rd(5'h08);
         chk("link_status", 8'h20, d);
      end
      ctl = 5'h18;
      wr(5'h10, {3'b000, ctl});
      xfer();
      wr(5'h04, ~tx);
      rd(5'h08);
      chk("overrun flags", 8'h03, {6'h00, d[7], d[3]});
      wait_bit(6);
      rd(5'h00);
      chk("receive_byte", exp_q.pop_front(), d);
      chk("peer byte", tx, srx);
      wr(5'h08, 8'h08);
      rd(5'h08);
      chk("link_status", 8'h20, d);
      xfer();
      wait_bit(6);
      xfer();
      wait_bit(2);
      rd(5'h08);
      chk("link_status", 8'he4, d);
      void'(exp_q.pop_front());
      rd(5'h00);
      chk("receive_byte", exp_q.pop_front(), d);
      wr(5'h08, 8'h80);
      rd(5'h08);
      chk("link_status", 8'h20, d);
      results();
   end
   initial begin
      repeat (60000) @(posedge clk);
      $display("CHECK FAILED run length expected done seen hang");
      fail_count++;
      results();
   end
endmodule
`default_nettype wire
